// [include/fsdi_pkg.sv]
// Functional notes
// - Mode pin low selects mode 0, high mode 1.
// - Mode high, both selects low: power down.
// - FSK from line amp; tone path selectable.
// - Mode 0 ignores shift clock, streams raw bits.
// - Mode 1 shift clock pulses advance buffered word.
// - Mode 1 drops start bit, buffers nine bits.
// - Ninth pulse presents stored stop bit.
// - Demodulator recovers 1200 baud async characters.
// - Word ready pulses low half bit at end.
// - First rising shift edge returns word ready high.
// - Mode 0 keeps word ready at one.
// - Carrier present output low while carrier detected.
package fsdi_pkg;
   localparam int          CLK_HZ        = 250000000;
   localparam int          BAUD          = 1200;
   localparam int          BIT_CYC       = CLK_HZ / BAUD;
   localparam int          HALF_CYC      = BIT_CYC / 2;
   localparam int          CNT_W         = 18;
   localparam int          WORD_W        = 9;
   localparam int          DATA_BITS     = 8;
   localparam int          STOP_POS      = 8;
   localparam int          IDX_W         = 4;
   // Status and mask bit positions.
   localparam int          EV_WORD       = 0;
   localparam int          EV_FRAME      = 1;
   localparam int          EV_CARRIER    = 2;
   localparam int          EV_W          = 3;
   // Register byte addresses.
   localparam logic [3:0]  ADR_STATUS    = 4'h0;
   localparam logic [3:0]  ADR_MASK      = 4'h4;
   localparam logic [3:0]  ADR_LAST      = 4'h8;
   localparam logic [3:0]  ADR_CTRL      = 4'hC;
   localparam logic [EV_W-1:0] MASK_RST  = 3'h0;
endpackage : fsdi_pkg

// [include/fsdi_rx_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface fsdi_rx_if;
   logic       word_stb;  // One-cycle pulse: character complete.
   logic [8:0] word;      // Data byte in low bits, stop bit on top.
   logic       busy;      // Character reception in progress.
   modport src (output word_stb, output word, output busy);
   modport dst (input word_stb, input word, input busy);
endinterface : fsdi_rx_if
`default_nettype wire

// [rtl/fsdi_rx.sv]
`timescale 1ns/100ps
`default_nettype none
module fsdi_rx
   import fsdi_pkg::*;
#(
   parameter int BIT_N = BIT_CYC // Clock cycles per bit, real rate by default.
)
(
   input  wire logic clock_i,  // System clock.
   input  wire logic rst_i,    // Synchronous reset.
   input  wire logic enable_i, // Receiver running.
   input  wire logic bit_i,    // Synchronised demodulated bit.
   fsdi_rx_if.src    rx        // Received character out.
);
   typedef enum logic [2:0] {
      FSDI_IDLE  = 3'b001,
      FSDI_START = 3'b010,
      FSDI_SHIFT = 3'b100
   } fsdi_rx_t;

   fsdi_rx_t         st_ff,  nxt_st;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [IDX_W-1:0] idx_ff, nxt_idx;
   logic [8:0]       sh_ff,  nxt_sh;
   logic             stb_ff, nxt_stb;

   // Sampling at mid-bit, timed from the start edge, recovers async data.
   always_comb begin
      nxt_st  = st_ff;
      nxt_cnt = cnt_ff;
      nxt_idx = idx_ff;
      nxt_sh  = sh_ff;
      nxt_stb = 1'b0;
      case (st_ff)
         FSDI_IDLE: begin
            if (enable_i && !bit_i) begin
               nxt_st  = FSDI_START;
               nxt_cnt = CNT_W'(BIT_N / 2 - 1);
            end
         end
         FSDI_START: begin
            if (cnt_ff != '0) begin
               nxt_cnt = cnt_ff - 1'b1;
            end else if (bit_i) begin
               nxt_st = FSDI_IDLE; // A glitch, not a start bit.
            end else begin
               // The start bit is checked and then dropped.
               nxt_st  = FSDI_SHIFT;
               nxt_cnt = CNT_W'(BIT_N - 1);
               nxt_idx = '0;
            end
         end
         FSDI_SHIFT: begin
            if (cnt_ff != '0) begin
               nxt_cnt = cnt_ff - 1'b1;
            end else begin
               nxt_sh  = {bit_i, sh_ff[8:1]};
               nxt_cnt = CNT_W'(BIT_N - 1);
               nxt_idx = idx_ff + 1'b1;
               if (idx_ff == IDX_W'(STOP_POS)) begin
                  nxt_st  = FSDI_IDLE;
                  nxt_stb = 1'b1;
               end
            end
         end
         default: nxt_st = FSDI_IDLE;
      endcase
      if (!enable_i) begin
         nxt_st = FSDI_IDLE;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_ff  <= FSDI_IDLE;
         cnt_ff <= '0;
         idx_ff <= '0;
         sh_ff  <= '0;
         stb_ff <= 1'b0;
      end else begin
         st_ff  <= nxt_st;
         cnt_ff <= nxt_cnt;
         idx_ff <= nxt_idx;
         sh_ff  <= nxt_sh;
         stb_ff <= nxt_stb;
      end
   end

   assign rx.word_stb = stb_ff;
   assign rx.word     = sh_ff;
   assign rx.busy     = (st_ff != FSDI_IDLE);
endmodule : fsdi_rx
`default_nettype wire

// [rtl/fsdi_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module fsdi_sync (
   input  wire logic clock_i,  // System clock.
   input  wire logic rst_i,    // Synchronous reset.
   input  wire logic async_i,  // Pin from outside the domain.
   output logic      sync_o    // Synchronised level.
);
   logic meta_ff;
   logic sync_ff;
   logic nxt_meta;
   logic nxt_sync;

   always_comb begin
      nxt_meta = async_i;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_o = sync_ff;
endmodule : fsdi_sync
`default_nettype wire

// [rtl/fsdi_top.sv]
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fsdi_top
   import fsdi_pkg::*;
#(
   parameter int BIT_N = BIT_CYC // Clock cycles per bit, real rate by default.
)
(
   input  wire logic        clock_i,                 // 250 MHz clock.
   input  wire logic        rst_i,                   // Sync reset, high.
   input  wire logic        interface_mode_select_i, // Mode pin.
   input  wire logic        function_select_hi_i,    // Function select 1.
   input  wire logic        function_select_lo_i,    // Function select 0.
   input  wire logic        line_amp_fsk_i,          // Line path bit.
   input  wire logic        hybrid_amp_tone_i,       // Hybrid tone level.
   input  wire logic        line_amp_tone_i,         // Line tone level.
   input  wire logic        carrier_detect_i,        // Carrier detected.
   input  wire logic        serial_shift_clock_i,    // Host shift clock.
   output logic             serial_data_o,           // Data pin.
   output logic             word_ready_n_o,          // Word ready, low.
   output logic             carrier_present_n_o,     // Carrier, low.
   output logic             power_down_o,            // Power-down state.
   output logic             tone_select_o,           // Chosen tone level.
   output logic             tone_path_hybrid_o,      // Tone on hybrid.
   input  wire logic [3:0]  wb_adr_i,                // Wishbone address.
   input  wire logic [31:0] wb_dat_i,                // Write data.
   output logic      [31:0] wb_dat_o,                // Read data.
   input  wire logic [3:0]  wb_sel_i,                // Byte selects.
   input  wire logic        wb_we_i,                 // Write enable.
   input  wire logic        wb_cyc_i,                // Cycle.
   input  wire logic        wb_stb_i,                // Strobe.
   output logic             wb_ack_o,                // Acknowledge.
   output logic             irq_o                    // Level interrupt.
);
   logic mode_s, fhi_s, flo_s, fsk_s, htone_s, ltone_s, cd_s, sck_s;

   fsdi_sync u_s0 (.clock_i(clock_i), .rst_i(rst_i),
                   .async_i(interface_mode_select_i), .sync_o(mode_s));
   fsdi_sync u_s1 (.clock_i(clock_i), .rst_i(rst_i),
                   .async_i(function_select_hi_i), .sync_o(fhi_s));
   fsdi_sync u_s2 (.clock_i(clock_i), .rst_i(rst_i),
                   .async_i(function_select_lo_i), .sync_o(flo_s));
   fsdi_sync u_s3 (.clock_i(clock_i), .rst_i(rst_i),
                   .async_i(line_amp_fsk_i), .sync_o(fsk_s));
   fsdi_sync u_s4 (.clock_i(clock_i), .rst_i(rst_i),
                   .async_i(hybrid_amp_tone_i), .sync_o(htone_s));
   fsdi_sync u_s5 (.clock_i(clock_i), .rst_i(rst_i),
                   .async_i(line_amp_tone_i), .sync_o(ltone_s));
   fsdi_sync u_s6 (.clock_i(clock_i), .rst_i(rst_i),
                   .async_i(carrier_detect_i), .sync_o(cd_s));
   fsdi_sync u_s7 (.clock_i(clock_i), .rst_i(rst_i),
                   .async_i(serial_shift_clock_i), .sync_o(sck_s));

   logic mode1;
   logic pdn;
   logic hybrid_sel;
   assign mode1 = mode_s;
   assign pdn   = mode_s && !fhi_s && !flo_s;
   // Tone from hybrid when only the low select is set; FSK never moves.
   assign hybrid_sel = !fhi_s && flo_s;

   fsdi_rx_if rxw ();
   fsdi_rx #(.BIT_N(BIT_N)) u_rx (
      .clock_i  (clock_i),
      .rst_i    (rst_i),
      .enable_i (!pdn),
      .bit_i    (fsk_s),
      .rx       (rxw.src)
   );

   // Shift-clock edge detection on the synchronised level.
   logic sck_d_ff, nxt_sck_d;
   logic sck_rise;
   assign sck_rise = sck_s && !sck_d_ff && mode1;

   logic [8:0]       buf_ff,  nxt_buf;
   logic [IDX_W-1:0] pos_ff,  nxt_pos;
   logic             dat_ff,  nxt_dat;
   logic             wr_ff,   nxt_wr;
   logic [CNT_W-1:0] wrc_ff,  nxt_wrc;
   logic [8:0]       last_ff, nxt_last;
   logic             cdn_ff,  nxt_cdn;
   logic             tone_ff, nxt_tone;

   always_comb begin
      nxt_sck_d = sck_s;
      nxt_buf   = buf_ff;
      nxt_pos   = pos_ff;
      nxt_dat   = dat_ff;
      nxt_wr    = wr_ff;
      nxt_wrc   = wrc_ff;
      nxt_last  = last_ff;
      nxt_cdn   = !cd_s;
      nxt_tone  = hybrid_sel ? htone_s : ltone_s;
      if (!mode1) begin
         nxt_dat = fsk_s;
         nxt_wr  = 1'b1;
         nxt_pos = '0;
      end else begin
         if (wr_ff == 1'b0) begin
            if (wrc_ff != '0) begin
               nxt_wrc = wrc_ff - 1'b1;
            end else begin
               nxt_wr = 1'b1;
            end
         end
         if (sck_rise) begin
            nxt_wr = 1'b1;
            // Each of the first nine rising edges puts the next bit out, LSB first.
            if (pos_ff < IDX_W'(WORD_W)) begin
               nxt_dat = buf_ff[pos_ff];
               nxt_pos = pos_ff + 1'b1;
            end
            // Pulse nine presents the stop bit.
            if (pos_ff == IDX_W'(STOP_POS)) begin
               nxt_dat = buf_ff[STOP_POS];
            end
         end
         if (rxw.word_stb) begin
            // A new word replaces the buffer even mid-read.
            nxt_buf  = rxw.word;
            nxt_pos  = '0;
            nxt_wr   = 1'b0;
            nxt_wrc  = CNT_W'(BIT_N / 2 - 1);
         end
      end
      if (rxw.word_stb) begin
         nxt_last = rxw.word;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sck_d_ff <= 1'b0;
         buf_ff   <= '0;
         pos_ff   <= '0;
         dat_ff   <= 1'b1;
         wr_ff    <= 1'b1;
         wrc_ff   <= '0;
         last_ff  <= '0;
         cdn_ff   <= 1'b1;
         tone_ff  <= 1'b0;
      end else begin
         sck_d_ff <= nxt_sck_d;
         buf_ff   <= nxt_buf;
         pos_ff   <= nxt_pos;
         dat_ff   <= nxt_dat;
         wr_ff    <= nxt_wr;
         wrc_ff   <= nxt_wrc;
         last_ff  <= nxt_last;
         cdn_ff   <= nxt_cdn;
         tone_ff  <= nxt_tone;
      end
   end

   // Interrupt status: sticky, write one to clear, set beats clear.
   logic [EV_W-1:0] ev;
   logic [EV_W-1:0] sts_ff, nxt_sts;
   logic [EV_W-1:0] msk_ff, nxt_msk;
   logic            ack_ff, nxt_ack;
   logic [31:0]     rd_ff,  nxt_rd;
   logic            cdn_d_ff, nxt_cdn_d;
   logic            req, wr_hit;

   assign req    = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr_hit = req && wb_we_i && wb_sel_i[0];
   assign ev[EV_WORD]    = rxw.word_stb;
   assign ev[EV_FRAME]   = rxw.word_stb && !rxw.word[STOP_POS];
   assign ev[EV_CARRIER] = !cdn_ff && cdn_d_ff;

   always_comb begin
      nxt_cdn_d = cdn_ff;
      nxt_ack   = req;
      nxt_msk   = msk_ff;
      nxt_rd    = rd_ff;
      nxt_sts   = sts_ff;
      if (wr_hit && wb_adr_i == ADR_STATUS) begin
         nxt_sts = sts_ff & ~wb_dat_i[EV_W-1:0];
      end else if (wr_hit && wb_adr_i == ADR_MASK) begin
         nxt_msk = wb_dat_i[EV_W-1:0];
      end
      nxt_sts = nxt_sts | ev;
      if (req) begin
         if (wb_adr_i == ADR_STATUS) begin
            nxt_rd = {29'h0, sts_ff};
         end else if (wb_adr_i == ADR_MASK) begin
            nxt_rd = {29'h0, msk_ff};
         end else if (wb_adr_i == ADR_LAST) begin
            nxt_rd = {23'h0, last_ff};
         end else if (wb_adr_i == ADR_CTRL) begin
            nxt_rd = {27'h0, rxw.busy, pdn, fhi_s, flo_s, mode_s};
         end else begin
            nxt_rd = 32'h0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cdn_d_ff <= 1'b1;
         ack_ff   <= 1'b0;
         msk_ff   <= MASK_RST;
         rd_ff    <= 32'h0;
         sts_ff   <= '0;
      end else begin
         cdn_d_ff <= nxt_cdn_d;
         ack_ff   <= nxt_ack;
         msk_ff   <= nxt_msk;
         rd_ff    <= nxt_rd;
         sts_ff   <= nxt_sts;
      end
   end

   assign wb_ack_o            = ack_ff;
   assign wb_dat_o            = rd_ff;
   assign irq_o               = |(sts_ff & msk_ff);
   assign serial_data_o       = dat_ff;
   assign word_ready_n_o      = wr_ff;
   assign carrier_present_n_o = cdn_ff;
   assign power_down_o        = pdn;
   assign tone_select_o       = tone_ff;
   assign tone_path_hybrid_o  = hybrid_sel;
endmodule : fsdi_top
`default_nettype wire

// [test/fsdi_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fsdi_host_model (
   input  wire logic       start_i,     // Rise starts a read burst.
   input  wire logic [3:0] pulses_i,    // Pulses in the burst.
   input  wire logic       data_i,      // Device data pin.
   output logic            shift_o,     // Shift clock, idle low.
   output logic [8:0]      word_o,      // Bits read, first in bit 0.
   output logic            frame_err_o, // Stop bit read as zero.
   output logic            done_o       // Burst finished.
);
   initial begin
      shift_o = 1'b0;
      word_o = 9'h000;
      frame_err_o = 1'b0;
      done_o = 1'b1;
   end
   // Sampling a nanosecond before a clock edge keeps clear of device updates.
   always @(posedge start_i) begin
      done_o = 1'b0;
      word_o = 9'h000;
      for (int i = 0; i < int'(pulses_i); i++) begin
         #(i == 0 ? 5 : 6) shift_o = 1'b1;
         #16 shift_o = 1'b0;
         #10 word_o[i] = data_i;
      end
      frame_err_o = (pulses_i == 4'h9) && !word_o[8];
      done_o = 1'b1;
   end
endmodule : fsdi_host_model
`default_nettype wire

// [test/fsdi_top_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module fsdi_top_properties
   import fsdi_pkg::*;
#(
   parameter int HALF_N = HALF_CYC // Half a bit in clock cycles.
)
(
   input wire logic clock_i,                 // Clock.
   input wire logic rst_i,                   // Reset.
   input wire logic interface_mode_select_i, // Mode pin.
   input wire logic function_select_hi_i,    // Select 1.
   input wire logic function_select_lo_i,    // Select 0.
   input wire logic line_amp_fsk_i,          // Raw bit.
   input wire logic hybrid_amp_tone_i,       // Hybrid tone.
   input wire logic carrier_detect_i,        // Carrier in.
   input wire logic serial_shift_clock_i,    // Shift clock.
   input wire logic serial_data_o,           // Data pin.
   input wire logic word_ready_n_o,          // Word ready.
   input wire logic carrier_present_n_o,     // Carrier out.
   input wire logic power_down_o,            // Power down.
   input wire logic tone_select_o,           // Chosen tone.
   input wire logic tone_path_hybrid_o,      // Hybrid path.
   input wire logic wb_cyc_i,                // Cycle.
   input wire logic wb_stb_i,                // Strobe.
   input wire logic wb_ack_o                 // Acknowledge.
);
   logic [CNT_W-1:0] low_cnt_ff;
   logic [CNT_W-1:0] nxt_low_cnt;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   always_comb begin
      nxt_low_cnt = word_ready_n_o ? '0 : low_cnt_ff + 1'b1;
   end
   always_ff @(posedge clock_i) begin
      low_cnt_ff <= rst_i ? '0 : nxt_low_cnt;
   end
   // Pins pass two-stage synchronisers, so each waits a few cycles first.
   a_power_down: assert property (
      (interface_mode_select_i && !function_select_hi_i &&
       !function_select_lo_i)[*3] |-> power_down_o)
      else $error("power down not entered");
   a_mode0_stream: assert property (
      (!interface_mode_select_i)[*6]
      |-> serial_data_o == $past(line_amp_fsk_i, 3))
      else $error("mode 0 data is not the delayed bit");
   a_mode0_ready: assert property (
      (!interface_mode_select_i)[*4] |-> word_ready_n_o)
      else $error("word ready low in mode 0");
   a_carrier_level: assert property (
      $stable(carrier_detect_i)[*6]
      |-> carrier_present_n_o == !carrier_detect_i)
      else $error("carrier output wrong");
   a_tone_hybrid: assert property (
      (!function_select_hi_i && function_select_lo_i &&
       $stable(hybrid_amp_tone_i))[*6]
      |-> tone_path_hybrid_o && tone_select_o == hybrid_amp_tone_i)
      else $error("tone not taken from hybrid path");
   a_ready_pulse: assert property (
      int'(low_cnt_ff) <= HALF_N + 1)
      else $error("word ready low too long");
   a_shift_clears: assert property (
      !word_ready_n_o && $rose(serial_shift_clock_i)
      |-> ##[1:8] word_ready_n_o)
      else $error("shift edge did not clear word ready");
   a_wb_ack_once: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle");
endmodule : fsdi_top_properties
bind fsdi_top fsdi_top_properties #(.HALF_N(BIT_N / 2)) i_props (.clock_i,
   .rst_i,
   .interface_mode_select_i, .function_select_hi_i, .function_select_lo_i,
   .line_amp_fsk_i, .hybrid_amp_tone_i, .carrier_detect_i,
   .serial_shift_clock_i, .serial_data_o, .word_ready_n_o,
   .carrier_present_n_o, .power_down_o, .tone_select_o, .tone_path_hybrid_o,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
   // Short bits keep a received character within a few hundred cycles.
   localparam int BIT_N = 64;
   typedef struct packed {
      logic [6:0] in;  // Mode, selects, bit, hybrid, line tone, carrier.
      logic [4:0] exp; // Power down, hybrid, tone, carrier, data.
   } fsdi_row_t;
   logic clock_i = 1'b0, rst_i = 1'b1, interface_mode_select_i = 1'b0;
   logic function_select_hi_i = 1'b1, function_select_lo_i = 1'b1;
   logic line_amp_fsk_i = 1'b1, hybrid_amp_tone_i = 1'b0;
   logic line_amp_tone_i = 1'b0, carrier_detect_i = 1'b0;
   logic serial_shift_clock_i, serial_data_o, word_ready_n_o, irq_o;
   logic carrier_present_n_o, power_down_o, tone_select_o;
   logic tone_path_hybrid_o, wb_ack_o, wb_we_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, start = 1'b0, frame_err, done;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF, pulses = 4'h9, outs;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [8:0] word;
   int mismatches = 0, total_checks = 0, cycles = 0, low_n = 0;
   fsdi_row_t rows [5] = '{'{7'h23, 5'h04}, '{7'h1C, 5'h0F},
      '{7'h48, 5'h12}, '{7'h7D, 5'h00}, '{7'h0E, 5'h07}};
   fsdi_row_t r;
   assign outs = {power_down_o, tone_path_hybrid_o, tone_select_o,
                  carrier_present_n_o};
   fsdi_top #(.BIT_N(BIT_N)) i_dut (.clock_i, .rst_i,
      .interface_mode_select_i,
      .function_select_hi_i, .function_select_lo_i, .line_amp_fsk_i,
      .hybrid_amp_tone_i, .line_amp_tone_i, .carrier_detect_i,
      .serial_shift_clock_i, .serial_data_o, .word_ready_n_o,
      .carrier_present_n_o, .power_down_o, .tone_select_o,
      .tone_path_hybrid_o, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i,
      .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq_o);
   fsdi_host_model i_host (.start_i(start), .pulses_i(pulses),
      .data_i(serial_data_o), .shift_o(serial_shift_clock_i),
      .word_o(word), .frame_err_o(frame_err), .done_o(done));
   always #2 clock_i = ~clock_i;
   task automatic stop_test();
      if (mismatches == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic wb(input logic we, input logic [3:0] adr,
                     input logic [31:0] wd, input logic [3:0] sel);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
      {wb_adr_i, wb_dat_i, wb_sel_i} <= {adr, wd, sel};
      @(posedge clock_i);
      while (wb_ack_o !== 1'b1) begin
         @(posedge clock_i);
      end
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
      @(posedge clock_i);
   endtask : wb
   task automatic burst(input logic [3:0] n);
      pulses <= n;
      start <= 1'b1;
      @(posedge clock_i);
      start <= 1'b0;
      while (done !== 1'b1) begin
         @(posedge clock_i);
      end
   endtask : burst
   // Start bit, eight data bits, then the stop bit until word ready drops.
   task automatic send(input logic [8:0] w);
      line_amp_fsk_i <= 1'b0;
      repeat (BIT_N) @(posedge clock_i);
      for (int b = 0; b < 8; b++) begin
         line_amp_fsk_i <= w[b];
         repeat (BIT_N) @(posedge clock_i);
      end
      line_amp_fsk_i <= w[8];
      while (word_ready_n_o !== 1'b0) begin
         @(posedge clock_i);
      end
      line_amp_fsk_i <= 1'b1;
   endtask : send
   initial begin
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      wb(1'b0, 4'h4, 32'h0, 4'hF);
      `CHK(rd, 32'h0)
      foreach (rows[i]) begin
         {interface_mode_select_i, function_select_hi_i, function_select_lo_i,
          line_amp_fsk_i, hybrid_amp_tone_i, line_amp_tone_i,
          carrier_detect_i} <= rows[i].in;
         repeat (8) @(posedge clock_i);
         `CHK(outs, rows[i].exp[4:1])
         if (!rows[i].in[6]) `CHK(serial_data_o, rows[i].exp[0])
         `CHK(word_ready_n_o, 1'b1)
         wb(1'b0, 4'hC, 32'h0, 4'hF);
         r = rows[i];
         `CHK(rd[3:0], {r.exp[4], r.in[5:4], r.in[6]})
      end
      // Mode 0 with the host clocking anyway: the raw bit must stay put.
      {interface_mode_select_i, line_amp_fsk_i} <= 2'h0;
      burst(4'h9);
      `CHK(serial_data_o, 1'b0)
      // A reset in mid-run also drops the half-received character.
      {interface_mode_select_i, function_select_hi_i, function_select_lo_i,
       line_amp_fsk_i} <= 4'hF;
      rst_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      `CHK({serial_data_o, word_ready_n_o, carrier_present_n_o}, 3'h7)
      `CHK({wb_ack_o, irq_o}, 2'h0)
      rst_i <= 1'b0;
      // Mode 1 before any word: nine pulses read zeros, stop bit included.
      repeat (6) @(posedge clock_i);
      burst(4'h9);
      `CHK(word, 9'h000)
      `CHK(frame_err, 1'b1)
      `CHK(word_ready_n_o, 1'b1)
      wb(1'b1, 4'h0, 32'h7, 4'hF);
      wb(1'b1, 4'h4, 32'h4, 4'hE);
      wb(1'b0, 4'h4, 32'h0, 4'hF);
      `CHK(rd, 32'h0)
      wb(1'b1, 4'h4, 32'h4, 4'hF);
      carrier_detect_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      `CHK(irq_o, 1'b1)
      wb(1'b0, 4'h0, 32'h0, 4'hF);
      `CHK(rd[2:0], 3'h4)
      wb(1'b1, 4'h0, 32'h4, 4'hF);
      `CHK(irq_o, 1'b0)
      wb(1'b1, 4'h4, 32'h0, 4'hF);
      carrier_detect_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      carrier_detect_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      `CHK(irq_o, 1'b0)
      wb(1'b0, 4'h0, 32'h0, 4'hF);
      `CHK(rd[2], 1'b1)
      wb(1'b0, 4'h1, 32'h0, 4'hF);
      `CHK(rd, 32'h0)
      wb(1'b1, 4'hC, 32'h1F, 4'hF);
      wb(1'b0, 4'hC, 32'h0, 4'hF);
      `CHK(rd[3:0], 4'h7)
      // Received characters in mode 1: a clean one, then a framing error.
      wb(1'b1, 4'h0, 32'h7, 4'hF);
      send(9'h1A5);
      `CHK(word_ready_n_o, 1'b0)
      low_n = 0;
      while (word_ready_n_o === 1'b0) begin
         @(posedge clock_i);
         low_n++;
      end
      `CHK(low_n, BIT_N / 2)
      wb(1'b0, 4'h8, 32'h0, 4'hF);
      `CHK(rd, 32'h1A5)
      wb(1'b0, 4'h0, 32'h0, 4'hF);
      `CHK(rd[2:0], 3'h1)
      burst(4'h9);
      `CHK(word, 9'h1A5)
      `CHK(frame_err, 1'b0)
      wb(1'b1, 4'h0, 32'h3, 4'hF);
      send(9'h0C3);
      `CHK(word_ready_n_o, 1'b0)
      burst(4'h1);
      `CHK({word_ready_n_o, word[0]}, 2'h3)
      burst(4'h8);
      `CHK(word, 9'h061)
      wb(1'b0, 4'h0, 32'h0, 4'hF);
      `CHK(rd[2:0], 3'h3)
      stop_test();
   end
endmodule : testbench
`default_nettype wire
